/* File: hdl/lad_pkg.sv */
// constants and carrier types of the limit and alert diagnostics block
package lad_pkg;
    // register addresses on the serial register port
    localparam logic [5:0] ADDR_DIAG_ALERT_FLAGS = 6'h0B;
    localparam logic [5:0] ADDR_SHUNT_HIGH_THRESHOLD = 6'h0C;
    localparam logic [5:0] ADDR_SHUNT_LOW_THRESHOLD = 6'h0D;
    // field positions of the diagnostic flag register
    localparam int BIT_ALERT_LATCH_SEL = 15;
    localparam int BIT_CONV_READY_ON_ALERT = 14;
    localparam int BIT_COMPARE_ON_AVERAGED_SEL = 13;
    localparam int BIT_ALERT_POLARITY_SEL = 12;
    localparam int BIT_ARITH_OVERFLOW_FLAG = 9;
    localparam int BIT_OVER_TEMP_FLAG = 7;
    localparam int BIT_SHUNT_OVER_FLAG = 6;
    localparam int BIT_SHUNT_UNDER_FLAG = 5;
    localparam int BIT_BUS_OVER_FLAG = 4;
    localparam int BIT_BUS_UNDER_FLAG = 3;
    localparam int BIT_POWER_OVER_FLAG = 2;
    localparam int BIT_CONV_DONE_FLAG = 1;
    localparam int BIT_TRIM_MEMORY_OK = 0;
    // reset values
    localparam logic [15:0] RST_SHUNT_HIGH_THRESHOLD = 16'h7FFF;
    localparam logic [15:0] RST_SHUNT_LOW_THRESHOLD = 16'h8000;
    localparam logic RST_TRIM_MEMORY_OK = 1'b1;
    // one measurement set from the converter chain
    typedef struct packed {
        logic [15:0] shunt;  // two's complement
        logic [15:0] bus;    // always positive
        logic [15:0] temp;   // two's complement in 15:4
        logic [23:0] power;  // unsigned
    } lad_meas_type;
    // thresholds held outside this block
    typedef struct packed {
        logic [14:0] bus_over;
        logic [14:0] bus_under;
        logic [11:0] temp_limit;
        logic [15:0] power_limit;
    } lad_limits_type;
    // limit event set produced by one comparison
    typedef struct packed {
        logic over_temp;
        logic shunt_over;
        logic shunt_under;
        logic bus_over;
        logic bus_under;
        logic power_over;
    } lad_events_type;
    // configuration bits of the flag register
    typedef struct packed {
        logic alert_latch_sel;
        logic conv_ready_on_alert;
        logic compare_on_averaged_sel;
        logic alert_polarity_sel;
    } lad_cfg_type;
endpackage : lad_pkg

/* File: hdl/lad_diag.sv */
// limit comparison, diagnostic flags and alert pin logic
`timescale 1ns/1ps
module lad_diag (
    // clock and reset
    // one clock, no enables needed
    // reset is synchronous
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register port from the serial interface
    // strobes are one cycle wide
    // answer comes one cycle later
    input wire logic [5:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // measurement chain
    // raw and averaged results
    // each with its own strobe
    // limits are static levels
    input wire lad_pkg::lad_meas_type raw_meas_i,
    input wire logic raw_valid_i,
    input wire lad_pkg::lad_meas_type avg_meas_i,
    input wire logic avg_valid_i,
    input wire lad_pkg::lad_limits_type limits_i,
    // conversion and arithmetic events
    // single-cycle pulses, any mix
    // checksum error may be a level
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic arith_overflow_i,
    input wire logic accum_clear_cmd_i,
    input wire logic trim_checksum_err_i,
    // open-drain alert pin
    // data tied low, enable moves
    output logic alert_o,
    output logic alert_oe_o
);
    // state organisation
    // all flops in one packed struct
    // one comb block builds the next
    // copy, one flop block stores it
    // packed, so one reset line
    // clears it; trim ok, thresholds load
    // cfg: four host select bits
    // ev: one flag per comparator
    // overflow: arithmetic unit only
    // done: end of each conversion
    // trim ok: one until bad checksum
    // thresholds: host written, signed
    // rdata, rvalid: read answer
    // no field has two writers
    // complete block state
    typedef struct packed {
        lad_pkg::lad_cfg_type cfg;
        lad_pkg::lad_events_type ev;
        logic arith_overflow_flag;
        logic conv_done_flag;
        logic trim_memory_ok;
        logic [15:0] shunt_high_threshold;
        logic [15:0] shunt_low_threshold;
        logic [15:0] rdata;
        logic rvalid;
    } lad_state_type;

    // helper nets, all combinational
    // cmp_meas, cmp_valid: chosen stream
    // hit: compare results this cycle
    // flag_word: read image of flags
    // read_flags: flag register read
    // alert_active: pin source decode
    lad_state_type state;
    lad_state_type next_state;
    lad_pkg::lad_meas_type cmp_meas;  // sample chosen for comparison
    logic cmp_valid;
    lad_pkg::lad_events_type hit;      // faults seen by this comparison
    logic [15:0] flag_word;
    logic read_flags;
    logic alert_active;

    // helpers
    // shunt and temperature are signed
    // bus and power are unsigned
    // a negative high threshold trips
    // at zero input, by intent
    // signed greater-than on 16-bit two's complement words
    function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction : sgt

    // flag register image
    // positions from the package only
    // bits 11:10 and 8 have no storage
    // built from registered state, so
    // a read sees pre-read flags
    // pack the flag register image, reserved bits held at zero
    function automatic logic [15:0] pack_flags(input lad_state_type s);
        logic [15:0] w;
        w = 16'h0000;
        // config bits, host owned
        w[lad_pkg::BIT_ALERT_LATCH_SEL] = s.cfg.alert_latch_sel;
        w[lad_pkg::BIT_CONV_READY_ON_ALERT] = s.cfg.conv_ready_on_alert;
        w[lad_pkg::BIT_COMPARE_ON_AVERAGED_SEL] = s.cfg.compare_on_averaged_sel;
        w[lad_pkg::BIT_ALERT_POLARITY_SEL] = s.cfg.alert_polarity_sel;
        // status bits, hardware owned
        w[lad_pkg::BIT_ARITH_OVERFLOW_FLAG] = s.arith_overflow_flag;
        w[lad_pkg::BIT_OVER_TEMP_FLAG] = s.ev.over_temp;
        w[lad_pkg::BIT_SHUNT_OVER_FLAG] = s.ev.shunt_over;
        w[lad_pkg::BIT_SHUNT_UNDER_FLAG] = s.ev.shunt_under;
        w[lad_pkg::BIT_BUS_OVER_FLAG] = s.ev.bus_over;
        w[lad_pkg::BIT_BUS_UNDER_FLAG] = s.ev.bus_under;
        w[lad_pkg::BIT_POWER_OVER_FLAG] = s.ev.power_over;
        w[lad_pkg::BIT_CONV_DONE_FLAG] = s.conv_done_flag;
        w[lad_pkg::BIT_TRIM_MEMORY_OK] = s.trim_memory_ok;
        pack_flags = w;
    endfunction : pack_flags

    // stream select
    // select low: every raw sample,
    // quickest alert
    // select high: finished average,
    // slower alert, less noise
    // the other strobe is dropped
    // a select write acts next cycle
    // choose which result stream feeds the comparators
    always_comb begin
        if (state.cfg.compare_on_averaged_sel) begin
            cmp_meas = avg_meas_i;
            cmp_valid = avg_valid_i;
        end else begin
            cmp_meas = raw_meas_i;
            cmp_valid = raw_valid_i;
        end
    end

    // comparators
    // all compares are strict:
    // equal to limit is no event
    // temp limit is 12 bits, lined up
    // with reading bits 15:4
    // shunt limits: full 16-bit words
    // in the shunt reading's scale,
    // same code in either range
    // bus never negative: unsigned
    // against {0, 15-bit limit}
    // power limit counts 256 steps:
    // upper 16 of 24 bits compared
    // results used only on cmp_valid
    // one sample is enough to trip,
    // there is no fault filtering
    // threshold comparators
    always_comb begin
        // temperature: 12-bit signed field in 15:4
        hit.over_temp = sgt(cmp_meas.temp, {limits_i.temp_limit, 4'h0});
        // signed so a negative high threshold trips at zero input
        hit.shunt_over = sgt(cmp_meas.shunt, state.shunt_high_threshold);
        // shunt below low limit
        hit.shunt_under = sgt(state.shunt_low_threshold, cmp_meas.shunt);
        // bus above over limit
        hit.bus_over = cmp_meas.bus > {1'b0, limits_i.bus_over};
        // bus below under limit
        hit.bus_under = cmp_meas.bus < {1'b0, limits_i.bus_under};
        // limit counts in units of 256 power steps
        hit.power_over = cmp_meas.power[23:8] > limits_i.power_limit;
    end

    // register decode
    // strobes already in this domain
    // read_flags is also the latched
    // clear strobe of the flags
    // unmapped reads answer zero,
    // unmapped writes are dropped
    // register read strobe on the flag register
    assign read_flags = reg_rd_i && (reg_addr_i == lad_pkg::ADDR_DIAG_ALERT_FLAGS);
    assign flag_word = pack_flags(state);

    // next-state priority, low first:
    // hold every field
    // read answer, config writes
    // read and start clears
    // hardware events, which win
    // set-wins: an event in the cycle
    // of a clearing read is not lost,
    // the host sees it next read
    // read plus write: old value read
    // next-state logic
    always_comb begin
        next_state = state;
        // rvalid follows every read strobe
        next_state.rvalid = reg_rd_i;

        // read data, unmapped addresses answer zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                lad_pkg::ADDR_DIAG_ALERT_FLAGS: next_state.rdata = flag_word;
                lad_pkg::ADDR_SHUNT_HIGH_THRESHOLD: next_state.rdata = state.shunt_high_threshold;
                lad_pkg::ADDR_SHUNT_LOW_THRESHOLD: next_state.rdata = state.shunt_low_threshold;
                default: next_state.rdata = 16'h0000;
            endcase
        end

        // writes: flag bits are owned by hardware, only config is written
        // thresholds take the word as is
        // no write side effect on flags
        if (reg_wr_i) begin
            case (reg_addr_i)
                lad_pkg::ADDR_DIAG_ALERT_FLAGS: begin
                    next_state.cfg.alert_latch_sel = reg_wdata_i[lad_pkg::BIT_ALERT_LATCH_SEL];
                    next_state.cfg.conv_ready_on_alert =
                        reg_wdata_i[lad_pkg::BIT_CONV_READY_ON_ALERT];
                    next_state.cfg.compare_on_averaged_sel =
                        reg_wdata_i[lad_pkg::BIT_COMPARE_ON_AVERAGED_SEL];
                    next_state.cfg.alert_polarity_sel =
                        reg_wdata_i[lad_pkg::BIT_ALERT_POLARITY_SEL];
                end
                lad_pkg::ADDR_SHUNT_HIGH_THRESHOLD: begin
                    next_state.shunt_high_threshold = reg_wdata_i;
                end
                lad_pkg::ADDR_SHUNT_LOW_THRESHOLD: begin
                    next_state.shunt_low_threshold = reg_wdata_i;
                end
                default: begin
                    next_state.rvalid = next_state.rvalid;  // unmapped write ignored
                end
            endcase
        end

        // latched: hold until flag read
        // transparent: mirror last compare,
        // a fault that goes away clears
        // on the next selected sample
        // limit flags: clear first, so a same-cycle event wins
        if (state.cfg.alert_latch_sel) begin
            if (read_flags) begin
                next_state.ev = '0;
            end
            if (cmp_valid) begin
                next_state.ev = next_state.ev | hit;
            end
        end else if (cmp_valid) begin
            // transparent: follow the latest comparison
            next_state.ev = hit;
        end

        // start clears in both modes;
        // read clears only when latched,
        // so a polling host keeps it
        // conversion done: new start clears, latched read clears too
        if (conv_start_i || (state.cfg.alert_latch_sel && read_flags)) begin
            next_state.conv_done_flag = 1'b0;
        end
        if (conv_done_i) begin
            next_state.conv_done_flag = 1'b1;
        end

        // warns current and power may be
        // invalid; read leaves it set
        // arithmetic overflow, not clearable by software read
        if (conv_start_i || accum_clear_cmd_i) begin
            next_state.arith_overflow_flag = 1'b0;
        end
        if (arith_overflow_i) begin
            next_state.arith_overflow_flag = 1'b1;
        end

        // reads one in normal operation;
        // no software path back to one
        // trim checksum failure sticks until power-on reset
        if (trim_checksum_err_i) begin
            next_state.trim_memory_ok = 1'b0;
        end
    end

    // reset and register copy
    // synchronous, active high
    // flags zero, trim ok one
    // config zero
    // thresholds at extreme codes,
    // so neither trips by default
    // constants only in reset branch
    // state register
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state <= '0;
            state.trim_memory_ok <= lad_pkg::RST_TRIM_MEMORY_OK;
            state.shunt_high_threshold <= lad_pkg::RST_SHUNT_HIGH_THRESHOLD;
            state.shunt_low_threshold <= lad_pkg::RST_SHUNT_LOW_THRESHOLD;
        end else begin
            state <= next_state;
        end
    end

    // alert decode
    // registered flags only, so the
    // pin moves one cycle after the
    // event and never glitches
    // sources: limit flags, overflow,
    // done when routed to the pin
    // transparent: drops with flags
    // latched: held until flag read
    // a flag read ends a latched limit
    // or done alert, there is no separate ack
    // alert is a decode of registered flags, no extra delay
    always_comb begin
        // any limit event
        alert_active = |state.ev;
        // overflow counts as an event
        alert_active = alert_active || state.arith_overflow_flag;
        // done only when routed
        if (state.cfg.conv_ready_on_alert && state.conv_done_flag) begin
            alert_active = 1'b1;
        end
    end

    // pin driver
    // enable high pulls the pin low
    // the board pull-up gives the
    // high level and a slow rise
    // open drain: pull low only; active-high mode releases when active
    assign alert_o = 1'b0;
    always_comb begin
        if (state.cfg.alert_polarity_sel) begin
            // active high: pulled while idle
            alert_oe_o = !alert_active;
        end else begin
            // active low: pulled while active
            alert_oe_o = alert_active;
        end
    end

    // read answer
    // rvalid: one cycle after the read
    // rdata holds until the next read
    // register port answer
    assign reg_rdata_o = state.rdata;
    assign reg_rvalid_o = state.rvalid;

    // known limitations
    // no software clear of trim status
    // an event at a latched read may
    // be read twice; kept, not lost
    // thresholds not range checked;
    // software keeps high above low
    // host writes to flag bits ignored
    // unmapped reads cost one answer
    // cycle like any other read
endmodule : lad_diag

/* File: sim/lad_diag_assertions.sv */
// assertion checker for the limit and alert diagnostics block
`timescale 1ns/1ps
module lad_diag_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [5:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // flag causes
    input wire logic raw_valid_i,
    input wire logic avg_valid_i,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic arith_overflow_i,
    input wire logic accum_clear_cmd_i,
    input wire logic trim_checksum_err_i,
    // alert pin
    input wire logic alert_o,
    input wire logic alert_oe_o
);
    logic [3:0] cfg; // shadow of latch, conv ready, averaged, polarity
    logic [5:0] rd_addr; // address of the last read
    logic trim_bad; // checksum error seen since reset
    logic rd_trim; // trim status the last read must show
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // shadow state; trim status taken before the read edge, as the read sees it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cfg <= 4'h0;
            trim_bad <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == lad_pkg::ADDR_DIAG_ALERT_FLAGS) cfg <= reg_wdata_i[15:12];
            if (trim_checksum_err_i) trim_bad <= 1'b1;
        end
        if (reg_rd_i) begin
            rd_addr <= reg_addr_i;
            rd_trim <= !trim_bad;
        end
    end
    // a flag read with no sample strobe or conversion done pulse beside it
    sequence quiet_rd;
        reg_rd_i && reg_addr_i == lad_pkg::ADDR_DIAG_ALERT_FLAGS && !raw_valid_i
            && !avg_valid_i && !conv_done_i;
    endsequence
    sequence flag_answer;
        reg_rvalid_o && rd_addr == lad_pkg::ADDR_DIAG_ALERT_FLAGS;
    endsequence
    reserved_zero_a: assert property (flag_answer |-> reg_rdata_o[11:10] == 2'h0 && !reg_rdata_o[8])
        else $error("reserved flag bits read nonzero");
    alert_data_a: assert property (alert_o == 1'b0)
        else $error("alert pin data not low");
    overflow_alert_a: assert property (arith_overflow_i |=> alert_oe_o ^ cfg[0])
        else $error("overflow did not raise alert");
    overflow_hold_a: assert property (arith_overflow_i ##1 (!conv_start_i && !accum_clear_cmd_i)[*3]
        |=> alert_oe_o ^ cfg[0]) else $error("overflow flag dropped early");
    done_alert_a: assert property (conv_done_i |=> !cfg[2] || (alert_oe_o ^ cfg[0]))
        else $error("conversion done not routed to alert");
    latched_clear_a: assert property ((cfg[3] and quiet_rd) ##1 quiet_rd |=> reg_rdata_o[7:1] == 7'h00)
        else $error("latched flags not cleared by read");
    trim_flag_a: assert property (flag_answer |-> reg_rdata_o[0] == rd_trim)
        else $error("trim memory status wrong");
    reset_idle_a: assert property ($fell(reset_i) |-> !alert_oe_o)
        else $error("alert pin pulled after reset");
endmodule : lad_diag_chk
bind lad_diag lad_diag_chk i_lad_diag_chk (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .raw_valid_i, .avg_valid_i, .conv_start_i,
    .conv_done_i, .arith_overflow_i, .accum_clear_cmd_i, .trim_checksum_err_i, .alert_o, .alert_oe_o);

/* File: sim/lad_host.sv */
// host side model: pulled-up alert pin and read word capture
`timescale 1ns/1ps
module lad_host (
    // clock and design outputs
    input wire logic ref_clk_i,
    input wire logic alert_o,
    input wire logic alert_oe_o,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // resolved pin and last read word
    output logic alert_pin_o,
    output logic [15:0] rd_data_o
);
    // pull-up wins whenever nobody pulls low
    assign alert_pin_o = alert_oe_o ? alert_o : 1'b1;
    // take the answer at the edge where it is valid
    always @(posedge ref_clk_i) begin
        if (reg_rvalid_o) begin
            rd_data_o <= reg_rdata_o;
        end
    end
endmodule : lad_host

/* File: sim/tb.sv */
// self-checking bench for the limit and alert diagnostics block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    localparam logic [5:0] AF = lad_pkg::ADDR_DIAG_ALERT_FLAGS; // short map names
    localparam logic [5:0] AH = lad_pkg::ADDR_SHUNT_HIGH_THRESHOLD;
    localparam logic [5:0] AL = lad_pkg::ADDR_SHUNT_LOW_THRESHOLD;
    localparam lad_pkg::lad_limits_type QUIET = {15'h7FFF, 15'h0000, 12'h7FF, 16'hFFFF};
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [5:0] reg_addr_i = 6'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    lad_pkg::lad_meas_type raw_meas_i = '0;
    lad_pkg::lad_meas_type avg_meas_i = '0;
    logic raw_valid_i = 1'b0;
    logic avg_valid_i = 1'b0;
    lad_pkg::lad_limits_type limits_i = '0;
    logic [4:0] ev = 5'h00; // trim err, clear, overflow, done, start
    wire conv_start_i = ev[0];
    wire conv_done_i = ev[1];
    wire arith_overflow_i = ev[2];
    wire accum_clear_cmd_i = ev[3];
    wire trim_checksum_err_i = ev[4];
    logic [15:0] reg_rdata_o;
    logic reg_rvalid_o, alert_o, alert_oe_o, alert_pin;
    logic [15:0] host_data, hi, lo, e, t;
    lad_pkg::lad_meas_type m;
    int err_count = 0;
    int n_compared = 0;
    always #5 ref_clk_i = !ref_clk_i;
    lad_diag i_lad_diag (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .reg_rvalid_o, .raw_meas_i, .raw_valid_i, .avg_meas_i, .avg_valid_i,
        .limits_i, .conv_start_i, .conv_done_i, .arith_overflow_i, .accum_clear_cmd_i,
        .trim_checksum_err_i, .alert_o, .alert_oe_o);
    lad_host i_lad_host (.ref_clk_i, .alert_o, .alert_oe_o, .reg_rdata_o, .reg_rvalid_o,
        .alert_pin_o(alert_pin), .rd_data_o(host_data));
    // expected limit flags of one sample; strict compares, shunt signed
    function automatic logic [15:0] expf(lad_pkg::lad_meas_type s, logic [15:0] h,
        logic [15:0] l, lad_pkg::lad_limits_type k);
        expf = 16'h0000;
        expf[7] = $signed(s.temp) > $signed({k.temp_limit, 4'h0});
        expf[6] = $signed(s.shunt) > $signed(h);
        expf[5] = $signed(s.shunt) < $signed(l);
        expf[4] = s.bus > {1'b0, k.bus_over};
        expf[3] = s.bus < {1'b0, k.bus_under};
        expf[2] = s.power[23:8] > k.power_limit;
    endfunction : expf
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr_reg
    // hold above one gives back-to-back reads; the last answer is compared
    task automatic rd_chk(input logic [5:0] a, input int hold, input logic [15:0] x);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        repeat (hold) @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 `CHK(host_data, x)
    endtask : rd_chk
    // one-cycle pulse of a sample or an event, then pin check once flags land
    task automatic send(input logic use_avg, input logic [4:0] v, input logic pin);
        @(posedge ref_clk_i);
        raw_meas_i <= m;
        avg_meas_i <= m;
        raw_valid_i <= !use_avg && v == 5'h00;
        avg_valid_i <= use_avg;
        ev <= v;
        @(posedge ref_clk_i);
        raw_valid_i <= 1'b0;
        avg_valid_i <= 1'b0;
        ev <= 5'h00;
        #1 `CHK(alert_pin, pin)
    endtask : send
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        t = 16'($urandom(7));
        m = '0;
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd_chk(AF, 1, 16'h0001);
        rd_chk(AH, 1, 16'h7FFF);
        rd_chk(AL, 1, 16'h8000);
        rd_chk(6'h3F, 1, 16'h0000);
        wr_reg(AH, 16'hFFF0); // negative high above low
        send(1'b0, 5'h00, 1'b0); // zero shunt trips
        rd_chk(AF, 1, 16'h0041);
        $display("test reset_and_signed done");
        for (int i = 0; i < 24; i++) begin
            hi = 16'($urandom());
            lo = 16'($urandom());
            if ($signed(hi) < $signed(lo)) {hi, lo} = {lo, hi};
            m = 72'({$urandom(), $urandom(), $urandom()});
            m.bus[15] = 1'b0;
            if (i == 0) m.shunt = hi;
            limits_i <= 58'({$urandom(), $urandom()});
            wr_reg(AH, hi);
            wr_reg(AL, lo);
            rd_chk(AH, 1, hi);
            e = expf(m, hi, lo, limits_i);
            send(1'b0, 5'h00, !(|e));
            rd_chk(AF, 1, e | 16'h0001);
        end
        wr_reg(AF, 16'h1FFF); // flag bits written are ignored
        rd_chk(AF, 1, e | 16'h1001);
        #1 `CHK(alert_pin, |e)
        $display("test random_limits done");
        limits_i <= QUIET;
        wr_reg(AH, 16'h0000);
        wr_reg(AL, 16'h8000);
        wr_reg(AF, 16'h2000);
        m = '0;
        send(1'b1, 5'h00, 1'b1);
        m.shunt = 16'h0010;
        send(1'b0, 5'h00, 1'b1); // raw stream ignored
        rd_chk(AF, 1, 16'h2001);
        send(1'b1, 5'h00, 1'b0);
        rd_chk(AF, 1, 16'h2041);
        wr_reg(AF, 16'h8000);
        send(1'b0, 5'h00, 1'b0);
        m = '0;
        send(1'b0, 5'h00, 1'b0); // fault gone, still held
        rd_chk(AF, 1, 16'h8041);
        rd_chk(AF, 2, 16'h8001);
        $display("test averaged_and_latched done");
        wr_reg(AF, 16'hC000);
        send(1'b0, 5'h02, 1'b0);
        rd_chk(AF, 1, 16'hC003);
        rd_chk(AF, 1, 16'hC001);
        send(1'b0, 5'h02, 1'b0);
        send(1'b0, 5'h01, 1'b1);
        send(1'b0, 5'h04, 1'b0);
        rd_chk(AF, 1, 16'hC201);
        rd_chk(AF, 1, 16'hC201);
        send(1'b0, 5'h01, 1'b1);
        send(1'b0, 5'h04, 1'b0);
        send(1'b0, 5'h08, 1'b1);
        send(1'b0, 5'h10, 1'b1);
        rd_chk(AF, 1, 16'hC000);
        $display("test events done");
        wrap_up();
    end
    // watchdog well beyond the expected run of about 380 cycles
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
endmodule : tb
